//--- hdl/nine_bit_uart.sv
// Functional notes
// [R1] nine-bit frame: start 0, eight data lsb first, ninth bit, stop 1
// [R2] buffer write starts sending and copies ninth bit into shifter
// [R3] real start waits for next rollover of the divide-by-16 counter
// [R4] shift start, nine bits, stop; set transmit-done as stop begins
// [R5] receive only when enabled; sample at 16x rate, start on fall
// [R6] falling edge resets the receive divide-by-16 counter at once
// [R7] majority of samples in cell states 7, 8 and 9
// [R8] start bit sampled high is a false start; go back to idle
// [R9] store frame only if receive-done clear and ninth bit accepted
// [R10] return to edge hunt during stop bit; stop bit not stored (the 8-bit mode stores it as the received ninth bit)
// [R11] mode 3 is mode 2 with programmable baud generator rate
// [R12] shift mode clock is system clock over 12 or over 2
// [R13] mode 2 rate is system clock over 64 or over 32
// [R14] 16-bit up-counter reload; rate is clock/(16*(65536-reload))
// [R15] ninth bit 1 marks address byte, 0 marks data byte
// [R16] mode 1 with multiproc enable needs stop bit 1 for receive-done
// [R17] multiproc nine-bit receive needs address match or broadcast
// [R18] node address compared under mask; mask 0 ignores a bit
// [R19] broadcast address is node address or mask; zeros ignored
// [R20] address and mask reset to zero, accepting any address
// [R21] error flags stay set until software clears them
// [R22] buffer write while sending sets collision, byte dropped
// [R23] frame done while receive-done pending sets overrun, data kept
// [R24] mode field: 00 shift, 01 8-bit, 10 9-bit fixed, 11 9-bit var
// [R25] software clears transmit-done and receive-done itself
// [R26] transmit line idles high
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module nine_bit_uart
  import nine_bit_uart_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // serial lines
  input  wire logic        rx_line,
  output logic             tx_line
);
  import nine_bit_uart_pkg::*;

  // registers
  logic [7:0]  rx_buf_q;
  logic [7:0]  node_address_q;
  logic [7:0]  node_address_mask_q;
  logic [15:0] baud_reload_q;
  logic        rx_done_flag_q, tx_done_flag_q, rx_ninth_bit_q;
  logic        tx_ninth_bit_q, rx_enable_q;
  logic        tx_collision_flag_q, rx_overrun_flag_q;
  logic        multiproc_enable_q, mode_sel_lo_q, mode_sel_hi_q;
  logic        shift_speed_sel_q, rate_double_q;
  logic        ack_q;
  logic [1:0]  mode;
  assign mode = {mode_sel_hi_q, mode_sel_lo_q}; // [R24]

  // bus decode: one wait state, answer on the second edge of a request
  logic [2:0] reg_idx;
  logic       wr_go, rd_go, be0, be1;
  assign reg_idx = address[4:2];
  assign wr_go   = write & ack_q;
  assign rd_go   = read & ack_q;
  assign be0     = byteenable[0];
  assign be1     = byteenable[1];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & ~ack_q);
    end
  end

  // 16x tick source
  logic [15:0] brg_q;
  logic [2:0]  fix_q;
  logic        tick16;
  logic        brg_roll;
  logic [2:0]  fix_lim;
  assign brg_roll = (brg_q == 16'hffff);
  assign fix_lim  = rate_double_q ? 3'(FIX_DIV_FAST - 1) :
                                    3'(FIX_DIV_SLOW - 1);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      brg_q <= RST_RELOAD;
    end else if (wr_go && reg_idx == REG_RELOAD_HI && be0) begin
      // restart from the new reload so a new rate applies at once
      brg_q <= {writedata[7:0], baud_reload_q[7:0]}; // [R14]
    end else if (brg_roll) begin
      brg_q <= baud_reload_q; // [R14]
    end else begin
      brg_q <= brg_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fix_q <= 3'h0;
    end else if (fix_q >= fix_lim) begin
      fix_q <= 3'h0; // [R13]
    end else begin
      fix_q <= fix_q + 3'h1;
    end
  end

  always_comb begin
    if (mode == MODE_9FIXED) begin
      tick16 = (fix_q >= fix_lim); // [R13]
    end else begin
      tick16 = brg_roll; // [R11] [R14]
    end
  end

  // shift-mode clock enable: only the rate is built here
  logic [3:0] sdiv_q;
  logic       shift_clk_q;
  logic [3:0] sdiv_lim;
  assign sdiv_lim = shift_speed_sel_q ? 4'(SHIFT_DIV_FAST - 1) :
                                        4'(SHIFT_DIV_SLOW - 1);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sdiv_q      <= 4'h0;
      shift_clk_q <= 1'b0;
    end else if (sdiv_q >= sdiv_lim) begin
      sdiv_q      <= 4'h0;
      shift_clk_q <= (mode == MODE_SHIFT); // [R12]
    end else begin
      sdiv_q      <= sdiv_q + 4'h1;
      shift_clk_q <= 1'b0;
    end
  end

  // transmitter
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } tx_state_type;
  tx_state_type tx_state_q;
  logic [3:0]  tx_div_q;
  logic [3:0]  tx_cnt_q;
  logic [10:0] tx_shift_q;
  logic        tx_roll;
  logic        buf_write;
  logic [3:0]  tx_last;
  assign tx_roll   = tick16 && tx_div_q == CELL_LAST;
  assign buf_write = wr_go && reg_idx == REG_BUFFER && be0;
  assign tx_last   = (mode == MODE_8BIT) ? TX_BITS - 4'd1 : TX_BITS;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_div_q <= 4'h0;
    end else if (tick16) begin
      tx_div_q <= tx_div_q + 4'h1; // [R3]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_shift_q <= 11'h7ff;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          if (buf_write) begin
            // start, data, ninth, stop, lsb out first
            tx_shift_q <= (mode == MODE_8BIT) ?
              {2'b11, writedata[7:0], 1'b0} :
              {1'b1, tx_ninth_bit_q, writedata[7:0], 1'b0}; // [R1] [R2]
            tx_state_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_roll) begin
            tx_state_q <= TX_SEND; // [R3]
            tx_cnt_q   <= 4'h0;
          end
        end
        TX_SEND: begin
          if (tx_roll) begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]}; // [R4]
            tx_cnt_q   <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == tx_last - 4'd1) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_line <= 1'b1;
    end else if (tx_state_q == TX_SEND) begin
      tx_line <= tx_shift_q[0];
    end else begin
      tx_line <= 1'b1; // [R26]
    end
  end

  // stop bit begins when the shifter exposes it
  logic tx_stop_start;
  assign tx_stop_start = tx_state_q == TX_SEND && tx_roll &&
                         tx_cnt_q == tx_last - 4'd2;

  // receiver input: three flops, change once second and third agree
  logic [2:0] rx_sync_q;
  logic       rx_clean_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_sync_q  <= 3'b111;
      rx_clean_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_line};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_clean_q <= rx_sync_q[2];
      end
    end
  end

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_BITS = 2'b10
  } rx_state_type;
  rx_state_type rx_state_q;
  logic       rx_prev_q;
  logic [3:0] rx_div_q;
  logic [3:0] rx_idx_q;
  logic [2:0] rx_samp_q;
  logic [8:0] rx_shift_q;
  logic       rx_fall, rx_bit, rx_take;
  logic       addr_ok, frame_ok, frame_end;
  logic [3:0] rx_end_idx;
  logic [7:0] bcast;

  assign rx_fall = rx_prev_q & ~rx_clean_q;
  assign rx_bit  = (rx_samp_q[0] & rx_samp_q[1]) |
                   (rx_samp_q[0] & rx_samp_q[2]) |
                   (rx_samp_q[1] & rx_samp_q[2]); // [R7]
  assign rx_take = tick16 && rx_div_q == SAMPLE_C + 4'd1;
  assign rx_end_idx = (mode == MODE_8BIT) ? RX_STOP_8 : RX_STOP_IDX;
  assign bcast = node_address_q | node_address_mask_q; // [R19]
  // address byte sits in rx_shift_q[7:0]; ninth bit in rx_shift_q[8]
  assign addr_ok =
    (((rx_shift_q[7:0] ^ node_address_q) & node_address_mask_q) == 8'h00)
    || (((rx_shift_q[7:0] ^ bcast) & bcast) == 8'h00); // [R17] [R18]
  // in the 8-bit mode the stop bit is rx_bit as the frame ends
  assign frame_ok = !multiproc_enable_q ||
    ((mode == MODE_8BIT) ? rx_bit :                  // [R16]
     (rx_shift_q[8] && addr_ok));                    // [R9] [R15] [R17]
  assign frame_end = rx_state_q == RX_BITS && rx_take &&
                     rx_idx_q == rx_end_idx && mode != MODE_SHIFT;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_clean_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_state_q <= RX_HUNT;
      rx_div_q   <= 4'h0;
      rx_idx_q   <= 4'h0;
      rx_samp_q  <= 3'b111;
      rx_shift_q <= 9'h000;
    end else begin
      unique case (rx_state_q)
        RX_HUNT: begin
          if (rx_fall && rx_enable_q && mode != MODE_SHIFT) begin // [R5]
            rx_div_q   <= 4'h0; // [R6]
            rx_idx_q   <= 4'h0;
            rx_state_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (tick16) begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == SAMPLE_A) rx_samp_q[0] <= rx_clean_q;
            if (rx_div_q == SAMPLE_B) rx_samp_q[1] <= rx_clean_q;
            if (rx_div_q == SAMPLE_C) rx_samp_q[2] <= rx_clean_q;
          end
          if (rx_take) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rx_bit) begin
              rx_state_q <= RX_HUNT; // [R8]
            end else if (rx_idx_q == rx_end_idx) begin
              rx_state_q <= RX_HUNT; // [R10]
            end else if (rx_idx_q != 4'h0) begin
              rx_shift_q <= {rx_bit, rx_shift_q[8:1]}; // [R1]
            end
          end
          if (!rx_enable_q) begin
            rx_state_q <= RX_HUNT; // [R5]
          end
        end
        default: rx_state_q <= RX_HUNT;
      endcase
    end
  end

  // register writes
  logic ctl_wr, mode_wr;
  assign ctl_wr  = wr_go && reg_idx == REG_CONTROL && be0;
  assign mode_wr = wr_go && reg_idx == REG_MODE && be0;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_ninth_bit_q      <= 1'b0;
      rx_enable_q         <= 1'b0;
      multiproc_enable_q  <= 1'b0;
      mode_sel_lo_q       <= 1'b0;
      mode_sel_hi_q       <= 1'b0;
      shift_speed_sel_q   <= 1'b0;
      rate_double_q       <= 1'b0;
      node_address_q      <= RST_BYTE; // [R20]
      node_address_mask_q <= RST_BYTE; // [R20]
      baud_reload_q       <= RST_RELOAD;
    end else begin
      if (ctl_wr) begin
        tx_ninth_bit_q <= writedata[CTL_TX_NINTH];
        rx_enable_q    <= writedata[CTL_RX_EN];
      end
      if (mode_wr) begin
        multiproc_enable_q <= writedata[MOD_MP_EN];
        mode_sel_lo_q      <= writedata[MOD_SEL_LO];
        mode_sel_hi_q      <= writedata[MOD_SEL_HI];
        shift_speed_sel_q  <= writedata[MOD_SHIFT_SPD];
        rate_double_q      <= writedata[MOD_RATE_DBL];
      end
      if (wr_go && reg_idx == REG_NODE_ADDR && be0) begin
        node_address_q <= writedata[7:0];
      end
      if (wr_go && reg_idx == REG_NODE_MASK && be0) begin
        node_address_mask_q <= writedata[7:0];
      end
      if (wr_go && reg_idx == REG_RELOAD_LO && be0) begin
        baud_reload_q[7:0] <= writedata[7:0];
      end
      if (wr_go && reg_idx == REG_RELOAD_HI && be0) begin
        baud_reload_q[15:8] <= writedata[7:0];
      end
    end
  end

  // flags: hardware set wins over software clear (write 0 clears)
  logic clr_rx_done, clr_tx_done, clr_col, clr_ovr;
  assign clr_rx_done = ctl_wr && !writedata[CTL_RX_DONE]; // [R25]
  assign clr_tx_done = ctl_wr && !writedata[CTL_TX_DONE]; // [R25]
  assign clr_col     = ctl_wr && !writedata[CTL_TX_COL];
  assign clr_ovr     = ctl_wr && !writedata[CTL_RX_OVR];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_done_flag_q      <= 1'b0;
      tx_collision_flag_q <= 1'b0;
    end else begin
      if (tx_stop_start) begin
        tx_done_flag_q <= 1'b1; // [R4]
      end else if (clr_tx_done) begin
        tx_done_flag_q <= 1'b0;
      end
      if (buf_write && tx_state_q != TX_IDLE) begin
        tx_collision_flag_q <= 1'b1; // [R22] [R21]
      end else if (clr_col) begin
        tx_collision_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_done_flag_q    <= 1'b0;
      rx_ninth_bit_q    <= 1'b0;
      rx_buf_q          <= RST_BYTE;
      rx_overrun_flag_q <= 1'b0;
    end else begin
      if (frame_end && frame_ok && !rx_done_flag_q) begin
        // eight shifts leave the 8-bit frame one place higher
        rx_buf_q       <= (mode == MODE_8BIT) ? rx_shift_q[8:1] :
                          rx_shift_q[7:0]; // [R9]
        rx_ninth_bit_q <= (mode == MODE_8BIT) ? rx_bit : rx_shift_q[8];
        rx_done_flag_q <= 1'b1;
      end else if (clr_rx_done) begin
        rx_done_flag_q <= 1'b0;
      end
      if (frame_end && frame_ok && rx_done_flag_q) begin
        rx_overrun_flag_q <= 1'b1; // [R23] [R21]
      end else if (clr_ovr) begin
        rx_overrun_flag_q <= 1'b0;
      end
    end
  end

  // read data, registered with the acknowledge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if ((read | write) & ~ack_q & read) begin
      unique case (reg_idx)
        REG_BUFFER:    readdata <= {24'h00_0000, rx_buf_q};
        REG_CONTROL:   readdata <= {25'h000_0000, rx_overrun_flag_q,
                         tx_collision_flag_q, rx_enable_q, tx_ninth_bit_q,
                         rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
        REG_MODE:      readdata <= {24'h00_0000, rate_double_q, 1'b0,
                         shift_speed_sel_q, 2'b00, mode_sel_hi_q,
                         mode_sel_lo_q, multiproc_enable_q};
        REG_RELOAD_LO: readdata <= {24'h00_0000, baud_reload_q[7:0]};
        REG_RELOAD_HI: readdata <= {24'h00_0000, baud_reload_q[15:8]};
        REG_NODE_ADDR: readdata <= {24'h00_0000, node_address_q};
        REG_NODE_MASK: readdata <= {24'h00_0000, node_address_mask_q};
        default:       readdata <= 32'h0000_0000;
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = be1 | rd_go | shift_clk_q;
endmodule

//--- hdl/nine_bit_uart_pkg.sv
package nine_bit_uart_pkg;
  // register indices (word addresses; byte address is index times four)
  localparam logic [2:0] REG_BUFFER     = 3'h0;
  localparam logic [2:0] REG_CONTROL    = 3'h1;
  localparam logic [2:0] REG_MODE       = 3'h2;
  localparam logic [2:0] REG_RELOAD_LO  = 3'h3;
  localparam logic [2:0] REG_RELOAD_HI  = 3'h4;
  localparam logic [2:0] REG_NODE_ADDR  = 3'h5;
  localparam logic [2:0] REG_NODE_MASK  = 3'h6;
  // control register fields
  localparam int CTL_RX_DONE   = 0;
  localparam int CTL_TX_DONE   = 1;
  localparam int CTL_RX_NINTH  = 2;
  localparam int CTL_TX_NINTH  = 3;
  localparam int CTL_RX_EN     = 4;
  localparam int CTL_TX_COL    = 5;
  localparam int CTL_RX_OVR    = 6;
  // mode register fields
  localparam int MOD_MP_EN     = 0;
  localparam int MOD_SEL_LO    = 1;
  localparam int MOD_SEL_HI    = 2;
  localparam int MOD_SHIFT_SPD = 5;
  localparam int MOD_RATE_DBL  = 7;
  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  // mode encodings
  localparam logic [1:0] MODE_SHIFT   = 2'b00;
  localparam logic [1:0] MODE_8BIT    = 2'b01;
  localparam logic [1:0] MODE_9FIXED  = 2'b10;
  localparam logic [1:0] MODE_9VAR    = 2'b11;
  // timing: fixed divides give the 16x tick
  localparam int    FIX_DIV_SLOW   = 64 / 16;
  localparam int    FIX_DIV_FAST   = 32 / 16;
  localparam int    SHIFT_DIV_SLOW = 12;
  localparam int    SHIFT_DIV_FAST = 2;
  localparam int    OVERSAMPLE     = 16;
  localparam logic [3:0] SAMPLE_A  = 4'd7;
  localparam logic [3:0] SAMPLE_B  = 4'd8;
  localparam logic [3:0] SAMPLE_C  = 4'd9;
  localparam logic [3:0] CELL_LAST = 4'd15;
  localparam logic [3:0] TX_BITS   = 4'd11;
  localparam logic [3:0] RX_NINTH_IDX = 4'd9;
  localparam logic [3:0] RX_STOP_IDX  = 4'd10;
  localparam logic [3:0] RX_STOP_8    = 4'd9;
endpackage

//--- testbench/nine_bit_uart_checker.sv
`timescale 1ns/1ps
module nine_bit_uart_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // serial
  input wire logic        tx_line
);
  // every bit period the bench sets up is a multiple of this cell
  localparam int CELL_CLKS = 32;
  // ten low bits of the slowest rate in use
  localparam int MAX_LOW   = 10 * 64;
  int low_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      low_cnt_q <= 0;
    end else if (!tx_line) begin
      low_cnt_q <= low_cnt_q + 1;
    end else begin
      low_cnt_q <= 0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_answer;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence

  a_request_answered: assert property ($rose(read || write) |-> s_answer)
    else $error("request not answered one cycle later");
  a_wait_one_cycle: assert property ($fell(waitrequest) |-> s_ack)
    else $error("waitrequest low for more than one cycle");
  a_wait_needs_req: assert property (!waitrequest |-> (read || write))
    else $error("waitrequest low without a request");
  a_unmapped_zero: assert property ((read && address[4:2] == 3'h7 &&
    !waitrequest) |-> readdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_reset_bus_quiet: assert property (disable iff (1'b0)
    !resetn |=> (waitrequest && readdata == 32'h0000_0000))
    else $error("bus outputs not quiet in reset");
  a_tx_reset_idle: assert property (disable iff (1'b0)
    !resetn |=> tx_line)
    else $error("serial output not high in reset");
  a_cell_multiple: assert property ((tx_line && low_cnt_q != 0) |->
    (low_cnt_q % CELL_CLKS) == 0)
    else $error("serial low run not whole bit cells");
  a_low_run_bound: assert property (low_cnt_q <= MAX_LOW)
    else $error("serial line low past the stop bit");
endmodule

bind nine_bit_uart nine_bit_uart_checker i_chk (
  .clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .tx_line(tx_line));

//--- testbench/nine_bit_uart_test.sv
`timescale 1ns/1ps
module nine_bit_uart_test;
  import nine_bit_uart_pkg::*;
  logic        clk_sys    = 1'b0;
  logic        resetn     = 1'b0;
  logic [4:0]  address    = 5'h00;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [31:0] writedata  = 32'h0000_0000;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_line;
  logic        tx_line;
  logic [7:0]  lfsr_q     = 8'h51;
  int          errors       = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  // last entry is the 8-bit frame mode
  logic [7:0]  mode_tab [5] = '{8'h84, 8'h04, 8'h06, 8'h06, 8'h02};
  logic [15:0] rl_tab   [5] = '{16'h0000, 16'h0000, 16'hfffe, 16'hfffc,
                                16'hfffe};
  int          bc_tab   [5] = '{32, 64, 32, 64, 32};
  // node, mask, address byte, ninth bit
  logic [31:0] mp_tab   [6] = '{32'ha4fa_a000, 32'ha4fa_a001, 32'ha4fa_a201,
                                32'ha4fa_fe01, 32'ha4fa_5c01, 32'h0000_3701};

  nine_bit_uart i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .rx_line(rx_line),
    .tx_line(tx_line));
  remote_uart_model i_peer (
    .clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("unexpected run length: expected below 60000 cycles");
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic accept(input logic [7:0] d, input logic n9,
    input logic [7:0] node, input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = node | mask;
    return n9 && (((d ^ node) & mask) == 8'h00 ||
                  ((d ^ bcast) & bcast) == 8'h00);
  endfunction

  task automatic bus(input logic [2:0] idx, input logic wr_en,
                     input logic [7:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_sys);
    address   <= {idx, 2'b00};
    writedata <= {24'h00_0000, wd};
    read      <= !wr_en;
    write     <= wr_en;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    check("bus answer", 32'(waitrequest), 32'h0000_0000);
    rdat = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask

  task automatic rd(input logic [2:0] idx, output logic [31:0] v);
    bus(idx, 1'b0, 8'h00, v);
  endtask

  // polls the control register until a flag rises or the limit passes
  task automatic wait_flag(input int b, output logic [31:0] v);
    for (int k = 0; k < 30; k++) begin
      rd(REG_CONTROL, v);
      if (v[b] === 1'b1) break;
    end
  endtask

  initial begin
    logic [31:0] v;
    logic [31:0] r;
    logic [15:0] rl;
    logic [7:0]  d;
    logic        e;
    int          cnt;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      check("reset value", v, 32'h0000_0000);
    end
    check("tx idle", 32'(tx_line), 32'h0000_0001);
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    check("unmapped", v, 32'h0000_0000);
    wr(REG_NODE_MASK, 8'h5a);
    rd(REG_NODE_MASK, v);
    check("mask rw", v, 32'h0000_005a);
    $display("test registers done");
    for (int m = 0; m < 5; m++) begin
      rl = rl_tab[m];
      wr(REG_RELOAD_LO, rl[7:0]);
      wr(REG_RELOAD_HI, rl[15:8]);
      wr(REG_MODE, mode_tab[m]);
      i_peer.bit_clks = bc_tab[m];
      for (int j = 0; j < 3; j++) begin
        lfsr_q = lfsr_next(lfsr_q);
        d = lfsr_q;
        wr(REG_CONTROL, {3'b000, 1'b1, d[0], 3'b000});
        cnt = i_peer.got_count;
        wr(REG_BUFFER, d);
        // second write lands while the first byte is still going out
        if (j == 0) wr(REG_BUFFER, ~d);
        for (int k = 0; k < 1500 && i_peer.got_count == cnt; k++)
          @(posedge clk_sys);
        check("tx data", 32'(i_peer.frame[7:0]), 32'(d));
        // in the 8-bit frame this position is the stop bit
        check("tx ninth", 32'(i_peer.frame[8]), 32'(d[0] | (m == 4)));
        check("tx stop", 32'(i_peer.frame[9]), 32'h0000_0001);
        rd(REG_CONTROL, v);
        check("tx done", 32'(v[CTL_TX_DONE]), 32'h0000_0001);
        check("collision", 32'(v[CTL_TX_COL]), 32'(j == 0));
        lfsr_q = lfsr_next(lfsr_q);
        i_peer.send_frame(lfsr_q, lfsr_q[7]);
        wait_flag(CTL_RX_DONE, v);
        check("rx ninth", 32'(v[CTL_RX_NINTH]), 32'(lfsr_q[7]));
        rd(REG_BUFFER, v);
        check("rx data", v, 32'(lfsr_q));
      end
      $display("test mode %0d done", m);
    end
    wr(REG_MODE, 8'h84);
    i_peer.bit_clks = 32;
    wr(REG_CONTROL, 8'h10);
    i_peer.send_frame(8'h3c, 1'b1);
    wait_flag(CTL_RX_DONE, v);
    i_peer.send_frame(8'hc3, 1'b0);
    wait_flag(CTL_RX_OVR, v);
    check("overrun", 32'(v[CTL_RX_OVR]), 32'h0000_0001);
    rd(REG_BUFFER, v);
    check("kept data", v, 32'h0000_003c);
    wr(REG_CONTROL, 8'h50);
    i_peer.send_frame(8'h99, 1'b0);
    wait_flag(CTL_RX_DONE, v);
    check("overrun held", 32'(v[CTL_RX_OVR]), 32'h0000_0001);
    rd(REG_BUFFER, v);
    check("after overrun", v, 32'h0000_0099);
    wr(REG_CONTROL, 8'h00);
    i_peer.send_frame(8'h55, 1'b1);
    wait_flag(CTL_RX_DONE, v);
    check("rx off", 32'(v[CTL_RX_DONE] | v[CTL_RX_OVR]), 32'h0000_0000);
    wr(REG_CONTROL, 8'h10);
    i_peer.glitch(10);
    rd(REG_CONTROL, v);
    check("false start", 32'(v[CTL_RX_DONE]), 32'h0000_0000);
    $display("test error flags done");
    wr(REG_MODE, 8'h85);
    for (int t = 0; t < 6; t++) begin
      v = mp_tab[t];
      wr(REG_NODE_ADDR, v[31:24]);
      wr(REG_NODE_MASK, v[23:16]);
      wr(REG_CONTROL, 8'h10);
      i_peer.send_frame(v[15:8], v[0]);
      wait_flag(CTL_RX_DONE, r);
      e = accept(v[15:8], v[0], v[31:24], v[23:16]);
      check("address match", 32'(r[CTL_RX_DONE]), 32'(e));
    end
    wr(REG_NODE_ADDR, 8'h5a);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_NODE_ADDR, v);
    check("address after reset", v, 32'h0000_0000);
    $display("test multiprocessor done");
    end_sim();
  end
endmodule

//--- testbench/remote_uart_model.sv
`timescale 1ns/1ps
module remote_uart_model (
  // clock
  input  wire logic clk_sys,
  // serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  int         bit_clks  = 32;
  int         got_count = 0;
  logic [9:0] frame;

  // line idles high so every start bit is a clean fall
  initial rx_line = 1'b1;

  // start 0, data lsb first, ninth bit, stop 1
  task automatic send_frame(input logic [7:0] data, input logic ninth);
    logic [10:0] bits;
    bits = {1'b1, ninth, data, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= bits[i];
      repeat (bit_clks) @(posedge clk_sys);
    end
  endtask

  // a start bit too short to survive mid-cell sampling
  task automatic glitch(input int clks);
    rx_line <= 1'b0;
    repeat (clks) @(posedge clk_sys);
    rx_line <= 1'b1;
    repeat (bit_clks * 12) @(posedge clk_sys);
  endtask

  // samples the device's frame in the middle of each cell
  initial forever begin
    @(negedge tx_line);
    repeat (bit_clks / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clks) @(posedge clk_sys);
      frame[i] = tx_line;
    end
    got_count++;
  end
endmodule
